// *** abce_core.sv ***
// execute unit: and accumulator with file, bit clear, six conditional branches
// assumes one ahb-lite master, zero-wait writes, one wait state on reads
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "abce_params.svh"

// Behaviour
// - and accumulator with file register; only negative and zero flags change
// - destination bit 0 writes accumulator, 1 writes back to file register
// - bank bit 0 uses access bank (up to 95 low, above that bank 15), 1 uses bank select register
// - extended mode, bank bit 0, address up to 95: indexed literal offset
// - bit clear zeroes selected bit, flags untouched, one single-word cycle
// - branch offset signed -128..127; taken target is pc plus 2 plus 2n
// - taken branch adds a no-op cycle; untaken continues next word, no flags
// - branch on carry only when carry is 1
// - branch on no carry only when carry is 0
// - branch on negative, printed encoding, only when negative is 1
// - branch on not negative only when negative is 0
// - branch on no overflow only when overflow is 0
// - branch on not zero only when zero is 0
module abce_core (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // status
   output logic             exec_busy
);
   logic [7:0]  mem [`ABCE_FILE_DEPTH];
   abce_pkg::abce_state_t st_q;
   logic [1:0]  nop_cnt_q;
   logic [15:0] ins_q;
   logic [`ABCE_EA_W-1:0] ea_q;
   logic [`ABCE_EA_W-1:0] base_q;
   logic [`ABCE_EA_W-1:0] faddr_q;
   logic [7:0]  opnd_q;
   logic [7:0]  res_q;
   logic [7:0]  w_q;
   logic [3:0]  bank_q;
   logic [4:0]  flags_q;
   logic [`ABCE_PC_W-1:0] pc_q;
   logic        ext_q;
   logic        take_q;
   logic        busy_q;
   logic        wr_pend_q;
   logic        rd_pend_q;
   logic [7:0]  addr_q;
   logic        hready_q;
   logic [31:0] hrdata_q;

   wire logic   bus_acc  = hsel && htrans[1] && hready;
   wire logic   idle     = (st_q == abce_pkg::ST_IDLE);
   wire logic   bus_wr   = wr_pend_q && idle;
   wire logic   is_and   = (ins_q[15:10] == `ABCE_OP_AND);
   wire logic   is_bclr  = (ins_q[15:12] == `ABCE_OP_BCLR);
   wire logic   dest_f   = ins_q[9];
   wire logic [`ABCE_PC_W-1:0] br_ofs = {{12{ins_q[7]}}, ins_q[7:0], 1'b0};

   function automatic logic [`ABCE_EA_W-1:0] resolve(input logic a, input logic [7:0] f,
      input logic ext, input logic [3:0] bank, input logic [`ABCE_EA_W-1:0] base);
      if (!a && ext && f <= `ABCE_ACC_LIMIT)
         resolve = base + {4'h0, f};
      else if (!a)
         resolve = (f <= `ABCE_ACC_LIMIT) ? {4'h0, f} : {`ABCE_ACC_HIBANK, f};
      else
         resolve = {bank, f};
   endfunction : resolve

   function automatic logic [1:0] br_eval(input logic [7:0] op, input logic [4:0] fl);
      // bit 1 marks a branch opcode, bit 0 says taken
      unique case (op)
         `ABCE_OP_BC:   br_eval = {1'b1, fl[`ABCE_FLG_C]};
         `ABCE_OP_BNC:  br_eval = {1'b1, !fl[`ABCE_FLG_C]};
         `ABCE_OP_BN:   br_eval = {1'b1, fl[`ABCE_FLG_N]};
         `ABCE_OP_BNN:  br_eval = {1'b1, !fl[`ABCE_FLG_N]};
         `ABCE_OP_BRANCH_ON_NO_OVERFLOW: br_eval = {1'b1, !fl[`ABCE_FLG_OV]};
         `ABCE_OP_BNZ:  br_eval = {1'b1, !fl[`ABCE_FLG_Z]};
         default:       br_eval = 2'h0;
      endcase
   endfunction : br_eval

   wire logic [1:0] br_now = br_eval(ins_q[15:8], flags_q);

   function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] st);
      unique case (a)
         `ABCE_OFF_CTRL:  rd_mux = st;
         default:         rd_mux = 32'h0;
      endcase
   endfunction : rd_mux

   // bus slave: reads wait one cycle so a preceding write lands first
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q    <= 8'h00;
         hready_q  <= 1'b1;
         hrdata_q  <= 32'h0;
      end else begin
         wr_pend_q <= bus_acc && hwrite;
         rd_pend_q <= bus_acc && !hwrite;
         if (bus_acc)
            addr_q <= haddr[7:0];
         if (bus_acc && !hwrite)
            hready_q <= 1'b0;
         if (rd_pend_q) begin
            hready_q <= 1'b1;
            unique case (addr_q)
               `ABCE_OFF_CTRL:  hrdata_q <= {31'h0, ext_q};
               `ABCE_OFF_ACCUM: hrdata_q <= {24'h0, w_q};
               `ABCE_OFF_BANK:  hrdata_q <= {28'h0, bank_q};
               `ABCE_OFF_FLAGS: hrdata_q <= {27'h0, flags_q};
               `ABCE_OFF_PC:    hrdata_q <= {11'h0, pc_q};
               `ABCE_OFF_INSTR: hrdata_q <= {15'h0, !idle, ins_q};
               `ABCE_OFF_INDEX: hrdata_q <= {20'h0, base_q};
               `ABCE_OFF_FADDR: hrdata_q <= {20'h0, faddr_q};
               `ABCE_OFF_FDATA: hrdata_q <= {24'h0, mem[faddr_q]};
               default:         hrdata_q <= rd_mux(addr_q, 32'h0);
            endcase
         end
      end
   end

   // configuration registers; writes while busy are dropped
   always_ff @(posedge clk) begin
      if (srst) begin
         ext_q   <= 1'b0;
         bank_q  <= 4'h0;
         base_q  <= 12'h000;
         faddr_q <= 12'h000;
      end else if (bus_wr) begin
         unique case (addr_q)
            `ABCE_OFF_CTRL:  ext_q   <= hwdata[0];
            `ABCE_OFF_BANK:  bank_q  <= hwdata[3:0];
            `ABCE_OFF_INDEX: base_q  <= hwdata[11:0];
            `ABCE_OFF_FADDR: faddr_q <= hwdata[11:0];
            default: ;
         endcase
      end
   end

   // sequencer: four phases per instruction cycle, extra four for a taken branch
   always_ff @(posedge clk) begin
      if (srst) begin
         st_q      <= abce_pkg::ST_IDLE;
         nop_cnt_q <= 2'h0;
         ins_q     <= 16'h0000;
         ea_q      <= 12'h000;
         opnd_q    <= 8'h00;
         res_q     <= 8'h00;
         take_q    <= 1'b0;
         busy_q    <= 1'b0;
      end else begin
         unique case (st_q)
            abce_pkg::ST_IDLE: begin
               if (bus_wr && addr_q == `ABCE_OFF_INSTR) begin
                  ins_q  <= hwdata[15:0];
                  st_q   <= abce_pkg::ST_DEC;
                  busy_q <= 1'b1;
               end
            end
            abce_pkg::ST_DEC: begin
               ea_q <= resolve(ins_q[8], ins_q[7:0], ext_q, bank_q, base_q);
               st_q <= abce_pkg::ST_RD;
            end
            abce_pkg::ST_RD: begin
               opnd_q <= mem[ea_q];
               st_q   <= abce_pkg::ST_PROC;
            end
            abce_pkg::ST_PROC: begin
               take_q <= br_now[1] && br_now[0];
               if (is_and)
                  res_q <= w_q & opnd_q;
               else
                  res_q <= opnd_q & ~(8'h01 << ins_q[11:9]);
               st_q <= abce_pkg::ST_WR;
            end
            abce_pkg::ST_WR: begin
               nop_cnt_q <= 2'h0;
               st_q <= take_q ? abce_pkg::ST_NOP : abce_pkg::ST_IDLE;
               busy_q <= take_q;
            end
            abce_pkg::ST_NOP: begin
               nop_cnt_q <= nop_cnt_q + 2'h1;
               if (nop_cnt_q == `ABCE_NOP_LAST) begin
                  st_q   <= abce_pkg::ST_IDLE;
                  busy_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // program counter written once, in the last phase
   always_ff @(posedge clk) begin
      if (srst)
         pc_q <= `ABCE_RST_PC;
      else if (st_q == abce_pkg::ST_WR)
         pc_q <= take_q ? pc_q + 21'h2 + br_ofs : pc_q + 21'h2;
      else if (bus_wr && addr_q == `ABCE_OFF_PC)
         pc_q <= hwdata[`ABCE_PC_W-1:0];
   end

   // accumulator and flags
   always_ff @(posedge clk) begin
      if (srst) begin
         w_q     <= 8'h00;
         flags_q <= `ABCE_RST_FLAGS;
      end else if (st_q == abce_pkg::ST_WR && is_and) begin
         if (!dest_f)
            w_q <= res_q;
         flags_q[`ABCE_FLG_N] <= res_q[7];
         flags_q[`ABCE_FLG_Z] <= (res_q == 8'h00);
      end else if (bus_wr && addr_q == `ABCE_OFF_ACCUM)
         w_q <= hwdata[7:0];
      else if (bus_wr && addr_q == `ABCE_OFF_FLAGS)
         flags_q <= hwdata[4:0];
   end

   // file space: no reset, software preloads it through the window
   always_ff @(posedge clk) begin
      if (st_q == abce_pkg::ST_WR && ((is_and && dest_f) || is_bclr))
         mem[ea_q] <= res_q;
      else if (bus_wr && addr_q == `ABCE_OFF_FDATA)
         mem[faddr_q] <= hwdata[7:0];
   end

   assign hreadyout = hready_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;
   // registered copy of the state decode, so the status pin is glitch free
   assign exec_busy = busy_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   wire logic in_wr = (st_q == abce_pkg::ST_WR);
   wire logic in_pr = (st_q == abce_pkg::ST_PROC);

   a_and_accum: assert property (
      in_wr && is_and && !dest_f |=> w_q == $past(res_q)
      && $past(res_q) == ($past(w_q, 3) & $past(opnd_q, 2)))
      else $error("and result not in accumulator");
   a_and_flags: assert property (
      in_wr && is_and |=> flags_q[`ABCE_FLG_Z] == ($past(res_q) == 8'h00)
      && flags_q[`ABCE_FLG_N] == $past(res_q[7]) && $stable(flags_q[`ABCE_FLG_C])
      && $stable(flags_q[`ABCE_FLG_OV]))
      else $error("and flags wrong");
   a_and_file: assert property (
      in_wr && is_and && dest_f |=> mem[ea_q] == $past(res_q) && $stable(w_q))
      else $error("and result not in file");
   a_bank_sel: assert property (st_q == abce_pkg::ST_RD && ins_q[8] |-> ea_q == {bank_q, ins_q[7:0]})
      else $error("banked address wrong");
   a_access_bank: assert property (
      st_q == abce_pkg::ST_RD && !ins_q[8] && !ext_q && ins_q[7:0] > 8'h5f
      |-> ea_q[11:8] == 4'hf)
      else $error("access bank high part wrong");
   a_indexed: assert property (
      st_q == abce_pkg::ST_RD && !ins_q[8] && ext_q && ins_q[7:0] <= 8'h5f
      |-> ea_q == base_q + {4'h0, ins_q[7:0]})
      else $error("indexed address wrong");
   a_bit_clear: assert property (
      in_pr && is_bclr |=> ##1 mem[ea_q][ins_q[11:9]] == 1'b0 && $stable(flags_q) && idle)
      else $error("bit clear wrong");
   a_br_target: assert property (
      in_wr && take_q |=> pc_q == $past(pc_q) + 21'h2 + {{12{ins_q[7]}}, ins_q[7:0], 1'b0})
      else $error("branch target wrong");
   a_taken_nop: assert property (
      in_wr && take_q |=> st_q == abce_pkg::ST_NOP ##1 (st_q == abce_pkg::ST_NOP && $stable(pc_q))[*3]
      ##1 (idle && $stable(pc_q)))
      else $error("taken branch second cycle wrong");
   a_untaken: assert property (
      in_wr && br_now[1] && !take_q |=> pc_q == $past(pc_q) + 21'h2 && $stable(flags_q) && idle)
      else $error("untaken branch wrong");
   a_pc_quiet: assert property (
      !in_wr && !(bus_wr && addr_q == `ABCE_OFF_PC) |=> $stable(pc_q))
      else $error("pc written outside the last phase");
   a_read_wait: assert property (bus_acc && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_write_zero: assert property (bus_acc && hwrite |=> hreadyout)
      else $error("write data phase waited");
   a_bc: assert property (in_pr && ins_q[15:8] == 8'he2 |=> take_q == $past(flags_q[0]))
      else $error("carry branch wrong");
   a_bnc: assert property (in_pr && ins_q[15:8] == 8'he3 |=> take_q == !$past(flags_q[0]))
      else $error("no carry branch wrong");
   a_bn: assert property (in_pr && ins_q[15:8] == 8'h6e |=> take_q == $past(flags_q[4]))
      else $error("negative branch wrong");
   a_bnn: assert property (in_pr && ins_q[15:8] == 8'he7 |=> take_q == !$past(flags_q[4]))
      else $error("not negative branch wrong");
   a_branch_on_no_overflow: assert property (in_pr && ins_q[15:8] == 8'he5 |=> take_q == !$past(flags_q[3]))
      else $error("no overflow branch wrong");
   a_bnz: assert property (in_pr && ins_q[15:8] == 8'he1 |=> take_q == !$past(flags_q[2]))
      else $error("not zero branch wrong");

   c_and_file: cover property (in_wr && is_and && dest_f);
   c_taken:    cover property (in_wr && take_q);
   c_untaken:  cover property (in_wr && br_now[1] && !take_q);
   c_bclr_idx: cover property (in_wr && is_bclr && ext_q && !ins_q[8]);
   c_refused:  cover property (wr_pend_q && !idle);
endmodule : abce_core
`default_nettype wire

// *** abce_params.svh ***
// constants for the and / bit-clear / conditional-branch execute block
// assumes 32-bit ahb-lite register access, one aligned word per register
`ifndef ABCE_PARAMS_SVH
`define ABCE_PARAMS_SVH
`define ABCE_PC_W        21
`define ABCE_EA_W        12
`define ABCE_FILE_DEPTH  4096
`define ABCE_OFF_CTRL    8'h00
`define ABCE_OFF_ACCUM   8'h04
`define ABCE_OFF_BANK    8'h08
`define ABCE_OFF_FLAGS   8'h0c
`define ABCE_OFF_PC      8'h10
`define ABCE_OFF_INSTR   8'h14
`define ABCE_OFF_INDEX   8'h18
`define ABCE_OFF_FADDR   8'h1c
`define ABCE_OFF_FDATA   8'h20
`define ABCE_FLG_C       0
`define ABCE_FLG_Z       2
`define ABCE_FLG_OV      3
`define ABCE_FLG_N       4
`define ABCE_RST_FLAGS   5'h00
`define ABCE_RST_PC      21'h000000
`define ABCE_OP_AND      6'h05
`define ABCE_OP_BCLR     4'h9
`define ABCE_OP_BC       8'he2
`define ABCE_OP_BNC      8'he3
`define ABCE_OP_BN       8'h6e
`define ABCE_OP_BNN      8'he7
`define ABCE_OP_BRANCH_ON_NO_OVERFLOW     8'he5
`define ABCE_OP_BNZ      8'he1
`define ABCE_ACC_LIMIT   8'h5f
`define ABCE_ACC_HIBANK  4'hf
`define ABCE_NOP_LAST    2'h3
`endif

// *** abce_pkg.sv ***
// types for the execute block
// assumes abce_params.svh is on the include path
`default_nettype none
package abce_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_DEC  = 6'h02,
      ST_RD   = 6'h04,
      ST_PROC = 6'h08,
      ST_WR   = 6'h10,
      ST_NOP  = 6'h20
   } abce_state_t;
endpackage : abce_pkg
`default_nettype wire

// *** abce_ahb_master.sv ***
// ahb-lite master model driving the execute block registers
// assumes one slave whose hreadyout is looped back as hready
`timescale 1ns/1ns
`default_nettype none
module abce_ahb_master (
   // clock and answer
   input  wire logic        clk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   // request
   output var  logic        hsel,
   output var  logic [31:0] haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // single word transfer; waits on hready with no assumed latency
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= w ? d : 32'h0;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask : xfer
endmodule : abce_ahb_master
`default_nettype wire

// *** and_bitclear_condbranch_exec_tb.sv ***
// self-checking bench for the execute block
// assumes abce_params.svh on the include path and the ahb master model
`timescale 1ns/1ns
`default_nettype none
`include "abce_params.svh"
module and_bitclear_condbranch_exec_tb;
   logic        clk;
   logic        srst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        exec_busy;
   int          errors;
   int          checks;
   int          cyc;

   abce_core u_dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .exec_busy(exec_busy));
   abce_ahb_master u_mst (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      u_mst.xfer(1'b1, {24'h0, a}, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      u_mst.xfer(1'b0, {24'h0, a}, 32'h0, q);
      chk(q, e);
   endtask : rd

   task automatic poke(input logic [31:0] a, input logic [31:0] d);
      wr(`ABCE_OFF_FADDR, a);
      wr(`ABCE_OFF_FDATA, d);
   endtask : poke

   task automatic peek(input logic [31:0] a, input logic [31:0] e);
      wr(`ABCE_OFF_FADDR, a);
      rd(`ABCE_OFF_FDATA, e);
   endtask : peek

   // busy length shows one or two instruction cycles; window covers both
   task automatic run(input logic [15:0] ins, input int nb);
      int n;
      n = 0;
      wr(`ABCE_OFF_INSTR, {16'h0, ins});
      repeat (12) begin
         @(posedge clk);
         if (exec_busy === 1'b1) n++;
      end
      chk(n, nb);
   endtask : run

   task automatic t_and;
      wr(`ABCE_OFF_FLAGS, 32'h09);
      wr(`ABCE_OFF_ACCUM, 32'h17);
      wr(`ABCE_OFF_PC, 32'h40);
      wr(`ABCE_OFF_BANK, 32'h3);
      poke(32'h20, 32'hc2);
      poke(32'h344, 32'h8f);
      run(16'h1420, 4);
      rd(`ABCE_OFF_ACCUM, 32'h02);
      rd(`ABCE_OFF_FLAGS, 32'h09);
      rd(`ABCE_OFF_PC, 32'h42);
      peek(32'h20, 32'hc2);
      wr(`ABCE_OFF_ACCUM, 32'h80);
      run(16'h1744, 4);
      peek(32'h344, 32'h80);
      rd(`ABCE_OFF_FLAGS, 32'h19);
      poke(32'h344, 32'h7f);
      run(16'h1544, 4);
      rd(`ABCE_OFF_ACCUM, 32'h00);
      rd(`ABCE_OFF_FLAGS, 32'h0d);
      $display("test and done");
   endtask : t_and

   task automatic t_bcf;
      wr(`ABCE_OFF_CTRL, 32'h1);
      wr(`ABCE_OFF_INDEX, 32'h200);
      wr(`ABCE_OFF_FLAGS, 32'h1f);
      poke(32'h210, 32'hc7);
      poke(32'h010, 32'hff);
      poke(32'hf60, 32'h01);
      run(16'h9e10, 4);
      peek(32'h210, 32'h47);
      peek(32'h010, 32'hff);
      run(16'h9060, 4);
      peek(32'hf60, 32'h00);
      rd(`ABCE_OFF_FLAGS, 32'h1f);
      wr(`ABCE_OFF_CTRL, 32'h0);
      $display("test bit clear done");
   endtask : t_bcf

   task automatic t_branch;
      logic [7:0]  op [6] = '{`ABCE_OP_BC, `ABCE_OP_BNC, `ABCE_OP_BN, `ABCE_OP_BNN, `ABCE_OP_BRANCH_ON_NO_OVERFLOW, `ABCE_OP_BNZ};
      int          fb [6] = '{`ABCE_FLG_C, `ABCE_FLG_C, `ABCE_FLG_N, `ABCE_FLG_N, `ABCE_FLG_OV, `ABCE_FLG_Z};
      logic        nd [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      logic [7:0]  n;
      logic [20:0] base;
      logic [20:0] e;
      logic [4:0]  t;
      logic [4:0]  f;
      for (int i = 0; i < 6; i++) begin
         n = (i % 2) ? 8'h7f : 8'h80;
         base = (i % 2) ? 21'h000100 : 21'h0;
         t = nd[i] ? (5'h01 << fb[i]) : (5'h1d & ~(5'h01 << fb[i]));
         for (int k = 0; k < 2; k++) begin
            f = k ? (t ^ 5'h1d) : t;
            wr(`ABCE_OFF_FLAGS, {27'h0, f});
            wr(`ABCE_OFF_PC, {11'h0, base});
            run({op[i], n}, k ? 4 : 8);
            e = k ? base + 21'd2 : base + 21'd2 + {{12{n[7]}}, n, 1'b0};
            rd(`ABCE_OFF_PC, {11'h0, e});
            rd(`ABCE_OFF_FLAGS, {27'h0, f});
         end
      end
      $display("test branch done");
   endtask : t_branch

   // writes while busy are dropped; readback; reset after the run ends
   task automatic t_regs;
      wr(`ABCE_OFF_ACCUM, 32'h3c);
      wr(`ABCE_OFF_BANK, 32'ha);
      wr(`ABCE_OFF_INDEX, 32'h5a5);
      wr(`ABCE_OFF_FLAGS, 32'h01);
      wr(`ABCE_OFF_INSTR, 32'he201);
      rd(`ABCE_OFF_INSTR, 32'h1e201);
      wr(`ABCE_OFF_ACCUM, 32'hc3);
      repeat (4) @(posedge clk);
      rd(`ABCE_OFF_ACCUM, 32'h3c);
      rd(`ABCE_OFF_INSTR, 32'he201);
      rd(`ABCE_OFF_BANK, 32'ha);
      rd(`ABCE_OFF_INDEX, 32'h5a5);
      rd(`ABCE_OFF_CTRL, 32'h0);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(`ABCE_OFF_ACCUM, 32'h0);
      rd(`ABCE_OFF_INDEX, 32'h0);
      $display("test registers done");
   endtask : t_regs

   task automatic finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // generous ceiling; the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      errors = 0;
      checks = 0;
      cyc = 0;
      srst = 1'b1;
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      rd(`ABCE_OFF_PC, 32'h0);
      rd(`ABCE_OFF_FLAGS, 32'h0);
      rd(8'h40, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      t_and();
      t_bcf();
      t_branch();
      t_regs();
      finish_test();
   end
endmodule : and_bitclear_condbranch_exec_tb
`default_nettype wire
